// ===== common/srmc_pkg.sv
package srmc_pkg;
  localparam int SRMC_ADDR_W = 14;
  localparam int SRMC_DEPTH = 16384;
  localparam int SRMC_CLK_PERIOD_NS = 40;
  // Access time of the memory (read data valid after address or enable)
  localparam int SRMC_ACCESS_NS = 85;
  localparam int SRMC_ACCESS_CYC =
    (SRMC_ACCESS_NS + SRMC_CLK_PERIOD_NS - 1) / SRMC_CLK_PERIOD_NS;
  // Write overlap least time, address_to_write_end_time
  localparam int SRMC_WR_NS = 65;
  localparam int SRMC_WR_CYC = (SRMC_WR_NS + SRMC_CLK_PERIOD_NS - 1) / SRMC_CLK_PERIOD_NS;
  // Output turn-off time after chip enable rises
  localparam int SRMC_OFF_NS = 30;
  localparam int SRMC_OFF_CYC = (SRMC_OFF_NS + SRMC_CLK_PERIOD_NS - 1) / SRMC_CLK_PERIOD_NS;
  localparam logic [3:0] SRMC_CNT_ZERO = 4'h0;
  typedef enum logic [2:0] {
    SRMC_IDLE,
    SRMC_RD_SEL,
    SRMC_RD_WAIT,
    SRMC_WR_SEL,
    SRMC_WR_HOLD,
    SRMC_RECOVER
  } srmc_state_t;
endpackage : srmc_pkg

// ===== rtl/srmc_ctrl.sv
`timescale 1ns/100ps
// What this block does
// - A write happens only during overlap of chip enable low and write enable low.
// - Setup and hold counted from last falling and first rising enable.
// - Either enable stays high while any address line changes.
// - Write enable stays high for the whole of a read.
// - Chip-enable-driven read pulses chip enable low per access; data follows after access time.
// - Address is valid no later than chip enable falling.
// - Address timing is counted from last valid line to first change.
module srmc_ctrl
  import srmc_pkg::*;
#(
  parameter int ADDR_W = SRMC_ADDR_W
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic req_wdata_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic rsp_rdata_o,
  output logic [ADDR_W-1:0] mem_addr_o,
  output logic mem_ce_n_o,
  output logic mem_we_n_o,
  output logic mem_din_o,
  input wire logic mem_dout_i
);
  //////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    srmc_state_t st;
    logic [3:0] cnt;
    logic [ADDR_W-1:0] addr;
    logic ce_n;
    logic we_n;
    logic din;
    logic rsp_valid;
    logic rdata;
  } srmc_regs_t;

  srmc_regs_t r;
  srmc_regs_t next_r;

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_r = r;
    next_r.rsp_valid = 1'b0;
    unique case (r.st)
      SRMC_IDLE: begin
        if (req_valid_i) begin
          // Address and data set while both enables are high
          next_r.addr = req_addr_i;
          next_r.din = req_wdata_i;
          next_r.cnt = SRMC_CNT_ZERO;
          next_r.st = req_write_i ? SRMC_WR_SEL : SRMC_RD_SEL;
        end
      end
      SRMC_RD_SEL: begin
        // Chip enable falls a cycle after address is stable
        next_r.ce_n = 1'b0;
        next_r.we_n = 1'b1;
        next_r.st = SRMC_RD_WAIT;
      end
      SRMC_RD_WAIT: begin
        if (r.cnt == 4'(SRMC_ACCESS_CYC - 1)) begin
          next_r.rdata = mem_dout_i;
          next_r.rsp_valid = 1'b1;
          next_r.ce_n = 1'b1;
          next_r.cnt = SRMC_CNT_ZERO;
          next_r.st = SRMC_RECOVER;
        end else begin
          next_r.cnt = r.cnt + 4'h1;
        end
      end
      SRMC_WR_SEL: begin
        // Write enable falls with chip enable so the output never turns on
        next_r.ce_n = 1'b0;
        next_r.we_n = 1'b0;
        next_r.st = SRMC_WR_HOLD;
      end
      SRMC_WR_HOLD: begin
        if (r.cnt == 4'(SRMC_WR_CYC - 1)) begin
          // Both enables rise together; address and data held after
          next_r.ce_n = 1'b1;
          next_r.we_n = 1'b1;
          next_r.rsp_valid = 1'b1;
          next_r.cnt = SRMC_CNT_ZERO;
          next_r.st = SRMC_RECOVER;
        end else begin
          next_r.cnt = r.cnt + 4'h1;
        end
      end
      SRMC_RECOVER: begin
        // Let the memory output turn off before the next access
        if (r.cnt == 4'(SRMC_OFF_CYC - 1)) begin
          next_r.st = SRMC_IDLE;
        end else begin
          next_r.cnt = r.cnt + 4'h1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '{st: SRMC_IDLE, cnt: SRMC_CNT_ZERO, addr: '0, ce_n: 1'b1, we_n: 1'b1,
             din: 1'b0, rsp_valid: 1'b0, rdata: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  assign req_ready_o = (r.st == SRMC_IDLE);
  assign rsp_valid_o = r.rsp_valid;
  assign rsp_rdata_o = r.rdata;
  assign mem_addr_o = r.addr;
  assign mem_ce_n_o = r.ce_n;
  assign mem_we_n_o = r.we_n;
  assign mem_din_o = r.din;
endmodule : srmc_ctrl

// ===== bench/srmc_checker.sv
`timescale 1ns/100ps
module srmc_checker import srmc_pkg::*; #(parameter int ADDR_W = SRMC_ADDR_W) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic req_ready_o,
  input wire logic rsp_valid_o,
  input wire logic [ADDR_W-1:0] mem_addr_o,
  input wire logic mem_ce_n_o,
  input wire logic mem_we_n_o,
  input wire logic mem_din_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence s_take; req_valid_i && req_ready_o; endsequence
  sequence s_wr; (!mem_ce_n_o && !mem_we_n_o)[*2]; endsequence
  a_we_in_ce: assert property (!mem_we_n_o |-> !mem_ce_n_o) else $error("we outside ce");
  a_addr_held: assert property (!mem_ce_n_o |-> $stable(mem_addr_o)) else $error("addr moved");
  a_din_held: assert property (!mem_we_n_o |-> $stable(mem_din_o)) else $error("din moved");
  a_ce_start: assert property (s_take |-> ##2 $fell(mem_ce_n_o)) else $error("ce late");
  a_addr_taken: assert property (s_take |=> mem_addr_o == $past(req_addr_i)) else $error("addr");
  a_read_span: assert property ($fell(mem_ce_n_o) && mem_we_n_o |->
    (!mem_ce_n_o && mem_we_n_o)[*3] ##1 (mem_ce_n_o && rsp_valid_o)) else $error("read");
  a_write_end: assert property ($fell(mem_we_n_o) |->
    s_wr ##1 (mem_ce_n_o && mem_we_n_o && rsp_valid_o)) else $error("write");
  a_pulse_one: assert property (rsp_valid_o |=> !rsp_valid_o && req_ready_o) else $error("rsp");
endmodule : srmc_checker
bind srmc_ctrl srmc_checker #(.ADDR_W(ADDR_W)) chk (.*);

// ===== bench/srmc_mem_model.sv
`timescale 1ns/100ps
module srmc_mem_model import srmc_pkg::*; (
  input wire logic [SRMC_ADDR_W-1:0] addr_i,
  input wire logic ce_n_i,
  input wire logic we_n_i,
  input wire logic din_i,
  output logic dout_o
);
  logic cells [SRMC_DEPTH];
  wire logic wr = !ce_n_i && !we_n_i;
  // Store when the first enable rises
  always @(negedge wr) cells[addr_i] = din_i;
  // Off state shows the inverse so a late sample is caught
  assign #80 dout_o = (!ce_n_i && we_n_i) ? cells[addr_i] : !cells[addr_i];
endmodule : srmc_mem_model

// ===== bench/test_srmc_ctrl.sv
`timescale 1ns/100ps
module test_srmc_ctrl import srmc_pkg::*; ;
  logic clk_sys_i = 1'b0, rst_i = 1'b1, req_valid_i = 1'b0, req_write_i = 1'b0, req_wdata_i = 1'b0;
  logic [13:0] req_addr_i = 14'h0000, mem_addr_o;
  logic req_ready_o, rsp_valid_o, rsp_rdata_o, mem_ce_n_o, mem_we_n_o, mem_din_o, mem_dout_i;
  int errors = 0, tests_run = 0, cyc = 0;
  always #20 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (++cyc == 600) begin
    errors++;
    conclude();
  end
  srmc_ctrl uut (.*);
  srmc_mem_model mem (.addr_i(mem_addr_o), .ce_n_i(mem_ce_n_o), .we_n_i(mem_we_n_o),
    .din_i(mem_din_o), .dout_o(mem_dout_i));
  task automatic chk(input logic s, input logic e, input string name = "rdata");
    tests_run++;
    errors += (s !== e);
    if (s !== e) $display("[FAIL] %s exp %b got %b", name, e, s);
  endtask : chk
  task automatic acc(input logic w, input logic [13:0] a, input logic d, output logic q);
    int n = 0;
    @(posedge clk_sys_i);
    req_valid_i <= 1'b1;
    req_write_i <= w;
    req_addr_i <= a;
    req_wdata_i <= d;
    @(posedge clk_sys_i);
    req_valid_i <= 1'b0;
    while (rsp_valid_o !== 1'b1 && n < 9) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    chk(rsp_valid_o, 1'b1, "rsp_valid");
    q = rsp_rdata_o;
  endtask : acc
  task automatic t_bounds();
    logic q;
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, {14{i[0]}}, i[1], q);
      acc(1'b0, {14{i[0]}}, 1'b0, q);
      chk(q, i[1]);
    end
  endtask : t_bounds
  task automatic t_isolate();
    logic q;
    acc(1'b1, 14'h1555, 1'b1, q);
    acc(1'b1, 14'h2aaa, 1'b0, q);
    acc(1'b0, 14'h1555, 1'b0, q);
    chk(q, 1'b1);
    acc(1'b0, 14'h3fff, 1'b0, q);
    chk(q, 1'b1);
  endtask : t_isolate
  task automatic conclude();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  initial begin
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_bounds();
    t_isolate();
    conclude();
  end
endmodule : test_srmc_ctrl
